//--- hw/snfe_core.sv
// serial nor flash front end: pin shifting, decode and address map
`timescale 1ns/1ps
`default_nettype none
module snfe_core #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h11, // arbitrary value
  parameter logic [7:0] JEDEC_TYPE = 8'h40, // arbitrary value
  parameter logic [7:0] JEDEC_CAP = 8'h12, // arbitrary value
  parameter logic [127:0] UNIQUE_ID =
    128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210 // arbitrary value
) (
  input wire logic clk_sys_in, // 50 MHz system clock
  input wire logic rst_in, // async reset, active high
  input wire logic sclk_in, // serial clock pin
  input wire logic select_n_in, // select pin, active low
  input wire logic bidir_lane_zero_in, // serial_in_pin level
  output logic bidir_lane_zero_out, // lane zero drive value
  output logic bidir_lane_zero_oe_out, // lane zero driven
  output logic out_lane_one_out, // serial out drive value
  output logic out_lane_one_oe_out, // serial out driven
  input wire logic protect_n_in, // write protect pin, active low
  output logic [snfe_pkg::ADDR_W-1:0] rd_addr_out, // array read address
  input wire logic [7:0] rd_data_in, // array byte at rd_addr_out
  output logic prog_valid_out, // program byte available
  input wire logic prog_ready_in, // array takes program byte
  output logic [snfe_pkg::ADDR_W-1:0] prog_addr_out, // byte address
  output logic [7:0] prog_data_out, // byte, zeros are programmed
  output logic op_start_out, // launch pulse
  output snfe_pkg::snfe_op_e op_kind_out, // launched operation
  output logic [snfe_pkg::ADDR_W-1:0] op_addr_out, // aligned base
  input wire logic op_done_in, // embedded operation finished
  output logic [7:0] status_out, // status byte
  output logic sleep_out, // deep sleep level
  output logic overrun_out // program byte lost this frame
);
  import snfe_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    snfe_state_e st;
    logic sclk_q;
    logic cs_q;
    logic [7:0] cmd;
    logic [7:0] sh;
    logic [2:0] bcnt;
    logic [2:0] pre;
    logic [ADDR_W-1:0] addr;
    logic [7:0] osh;
    logic [3:0] idx;
    logic o0;
    logic o1;
    logic drv;
    logic dual;
    logic got;
    logic write_arm_latch;
    logic busy;
    logic sleep;
    logic status_lock_enable;
    logic [2:0] guard;
    logic [7:0] wsr;
    logic pend;
    logic [PW_W-1:0] pw;
    logic start;
    snfe_op_e kind;
    logic [ADDR_W-1:0] oaddr;
    logic ovr;
  } snfe_core_s;

  snfe_core_s r_reg;
  snfe_core_s r_next;
  logic [3:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  logic protect_n_s;
  logic fifo_ready;
  logic [7:0] status_b;

  // ---------------------------------------------------------------
  // pin synchronisers and program fifo
  // ---------------------------------------------------------------
  snfe_sync #(
    .W(4)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in({sclk_in, select_n_in, bidir_lane_zero_in, protect_n_in}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[3];
  assign cs_n_s = pins_s[2];
  assign din_s = pins_s[1];
  assign protect_n_s = pins_s[0];

  snfe_fifo #(
    .W(PW_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(r_reg.pend),
    .in_ready_out(fifo_ready),
    .in_data_in(r_reg.pw),
    .out_valid_out(prog_valid_out),
    .out_ready_in(prog_ready_in),
    .out_data_out({prog_addr_out, prog_data_out})
  );

  // status byte: lock, guard bits, arm latch, busy
  assign status_b = {r_reg.status_lock_enable, 2'b00, r_reg.guard, r_reg.write_arm_latch, r_reg.busy};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic rise;
    logic fall;
    logic cs_rise;
    logic cs_fall;
    logic acc;
    logic [7:0] nb;
    logic [7:0] ob;
    rise = sclk_s & ~r_reg.sclk_q;
    fall = ~sclk_s & r_reg.sclk_q;
    cs_rise = cs_n_s & ~r_reg.cs_q;
    cs_fall = ~cs_n_s & r_reg.cs_q; // needs a high first
    acc = r_reg.pend & fifo_ready;
    nb = {r_reg.sh[6:0], din_s}; // msb first
    ob = r_reg.osh;
    r_next = r_reg;
    r_next.start = 1'b0;
    r_next.sclk_q = sclk_s;
    r_next.cs_q = cs_n_s;
    // completion clears busy; a launch below still wins
    if (op_done_in)
      r_next.busy = 1'b0;
    if (acc)
      r_next.pend = 1'b0;

    if (cs_rise)
    begin
      // end of frame: release pins and run the framed operation
      r_next.st = ST_IDLE;
      r_next.drv = 1'b0;
      r_next.dual = 1'b0;
      case (r_reg.cmd)
        CMD_PAGE_WRITE:
          if (r_reg.st == ST_DIN && r_reg.got && r_reg.write_arm_latch)
          begin
            r_next.kind = OP_PROG;
            r_next.oaddr = r_reg.addr & PAGE_MASK;
            r_next.start = 1'b1;
          end
        CMD_FOUR_K_WIPE:
          if (r_reg.st == ST_HOLD && r_reg.write_arm_latch)
          begin
            r_next.kind = OP_SECTOR;
            r_next.oaddr = r_reg.addr & SECTOR_MASK;
            r_next.start = 1'b1;
          end
        CMD_HALF_WIPE:
          if (r_reg.st == ST_HOLD && r_reg.write_arm_latch)
          begin
            r_next.kind = OP_HALF;
            r_next.oaddr = r_reg.addr & HALF_MASK;
            r_next.start = 1'b1;
          end
        CMD_BLOCK_WIPE:
          if (r_reg.st == ST_HOLD && r_reg.write_arm_latch)
          begin
            r_next.kind = OP_BLOCK;
            r_next.oaddr = r_reg.addr & BLOCK_MASK;
            r_next.start = 1'b1;
          end
        CMD_ARRAY_WIPE_A, CMD_ARRAY_WIPE_B:
          if (r_reg.st == ST_HOLD && r_reg.write_arm_latch)
          begin
            r_next.kind = OP_CHIP;
            r_next.oaddr = ADDR_RST;
            r_next.start = 1'b1;
          end
        CMD_WR_STATUS:
          // locked while lock bit set and protect pin low
          if (r_reg.st == ST_DIN && r_reg.got && r_reg.write_arm_latch &&
              !(r_reg.status_lock_enable && !protect_n_s))
          begin
            r_next.status_lock_enable = r_reg.wsr[7];
            r_next.guard = r_reg.wsr[4:2];
            r_next.kind = OP_STATUS;
            r_next.oaddr = ADDR_RST;
            r_next.start = 1'b1;
          end
        CMD_DEEP_SLEEP:
          if (r_reg.st == ST_HOLD)
            r_next.sleep = 1'b1;
        default: ;
      endcase
      if (r_next.start)
      begin
        r_next.busy = 1'b1;
        r_next.write_arm_latch = 1'b0;
      end
    end
    else if (cs_fall)
    begin
      // new frame
      r_next.st = ST_CMD;
      r_next.bcnt = '0;
      r_next.got = 1'b0;
      r_next.ovr = 1'b0;
      r_next.idx = '0;
      r_next.drv = 1'b0;
      r_next.dual = 1'b0;
    end
    else if (rise)
    begin
      // input side, every rising edge
      case (r_reg.st)
        ST_CMD:
        begin
          r_next.sh = nb;
          r_next.bcnt = r_reg.bcnt + 1'b1;
          if (r_reg.bcnt == LAST_BIT)
          begin
            r_next.cmd = nb;
            r_next.st = ST_SKIP;
            r_next.pre = ADDR_BYTES;
            if ((r_reg.busy && nb != CMD_RD_STATUS) ||
                (r_reg.sleep && nb != CMD_WAKE_ID))
              r_next.st = ST_SKIP;
            else
              case (nb)
                CMD_WR_ENABLE:
                  r_next.write_arm_latch = 1'b1;
                CMD_WR_DISABLE:
                  r_next.write_arm_latch = 1'b0;
                CMD_RD_STATUS, CMD_JEDEC_IDENT:
                  r_next.st = ST_DOUT;
                CMD_WR_STATUS:
                  r_next.st = ST_DIN;
                CMD_ARRAY_WIPE_A, CMD_ARRAY_WIPE_B, CMD_DEEP_SLEEP:
                  r_next.st = ST_HOLD;
                CMD_WAKE_ID:
                begin
                  r_next.sleep = 1'b0;
                  r_next.st = ST_ADDR;
                end
                CMD_READ, CMD_PAGE_WRITE, CMD_FOUR_K_WIPE,
                CMD_HALF_WIPE, CMD_BLOCK_WIPE, CMD_MAKER_ID:
                  r_next.st = ST_ADDR;
                CMD_FAST_READ, CMD_DUAL_READ, CMD_UNIQUE_ID:
                begin
                  r_next.pre = ADDR_DUMMY_BYTES;
                  r_next.st = ST_ADDR;
                end
                default: ;
              endcase
          end
        end
        ST_ADDR:
        begin
          r_next.sh = nb;
          r_next.bcnt = r_reg.bcnt + 1'b1;
          if (r_reg.bcnt == LAST_BIT)
          begin
            // three address bytes; the fast and dual read dummy byte is not kept
            if (r_reg.pre != 3'd1 || (r_reg.cmd != CMD_FAST_READ &&
                r_reg.cmd != CMD_DUAL_READ))
              r_next.addr = {r_reg.addr[ADDR_W-9:0], nb};
            r_next.pre = r_reg.pre - 1'b1;
            if (r_reg.pre == 3'd1)
              case (r_reg.cmd)
                CMD_PAGE_WRITE:
                  r_next.st = ST_DIN;
                CMD_FOUR_K_WIPE, CMD_HALF_WIPE, CMD_BLOCK_WIPE:
                  r_next.st = ST_HOLD;
                default:
                begin
                  r_next.st = ST_DOUT;
                  r_next.dual = (r_reg.cmd == CMD_DUAL_READ);
                end
              endcase
          end
        end
        ST_DIN:
        begin
          r_next.sh = nb;
          r_next.bcnt = r_reg.bcnt + 1'b1;
          if (r_reg.bcnt == LAST_BIT)
          begin
            if (r_reg.cmd == CMD_WR_STATUS)
            begin
              if (!r_reg.got)
                r_next.wsr = nb;
              r_next.got = 1'b1;
            end
            else if (r_reg.write_arm_latch)
            begin
              // byte to the fifo; address wraps inside the page
              r_next.got = 1'b1;
              r_next.ovr = r_reg.ovr | (r_reg.pend & ~acc);
              r_next.pend = 1'b1;
              r_next.pw = {r_reg.addr, nb};
              r_next.addr[7:0] = r_reg.addr[7:0] + 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    else if (fall && r_reg.st == ST_DOUT)
    begin
      // output side, every falling edge
      if (r_reg.bcnt == '0)
      begin
        case (r_reg.cmd)
          CMD_RD_STATUS:
            ob = status_b;
          CMD_JEDEC_IDENT:
            ob = (r_reg.idx == 4'd0) ? MAKER_ID :
                 (r_reg.idx == 4'd1) ? JEDEC_TYPE : JEDEC_CAP;
          CMD_MAKER_ID:
            ob = r_reg.idx[0] ? DEVICE_ID : MAKER_ID;
          CMD_WAKE_ID:
            ob = DEVICE_ID;
          CMD_UNIQUE_ID:
            ob = UNIQUE_ID[8 * (15 - r_reg.idx) +: 8];
          default:
            ob = rd_data_in;
        endcase
        r_next.idx = r_reg.idx + 1'b1;
        if (r_reg.cmd == CMD_JEDEC_IDENT && r_reg.idx == JEDEC_LAST)
          r_next.idx = '0;
        if (r_reg.cmd == CMD_READ || r_reg.cmd == CMD_FAST_READ ||
            r_reg.cmd == CMD_DUAL_READ)
          r_next.addr = r_reg.addr + 1'b1;
      end
      r_next.o1 = ob[7];
      r_next.o0 = ob[6];
      r_next.drv = 1'b1;
      if (r_reg.dual)
      begin
        r_next.osh = {ob[5:0], 2'b00};
        r_next.bcnt = r_reg.bcnt + 3'd2;
      end
      else
      begin
        r_next.osh = {ob[6:0], 1'b0};
        r_next.bcnt = r_reg.bcnt + 3'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.cmd <= BYTE_RST;
      r_reg.guard <= GUARD_RST;
      r_reg.addr <= ADDR_RST;
      r_reg.kind <= OP_PROG;
    end
    else
      r_reg <= r_next;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign out_lane_one_out = r_reg.o1;
  assign out_lane_one_oe_out = r_reg.drv;
  assign bidir_lane_zero_out = r_reg.o0;
  assign bidir_lane_zero_oe_out = r_reg.drv & r_reg.dual;
  assign rd_addr_out = r_reg.addr;
  assign op_start_out = r_reg.start;
  assign op_kind_out = r_reg.kind;
  assign op_addr_out = r_reg.oaddr;
  assign status_out = status_b;
  assign sleep_out = r_reg.sleep;
  assign overrun_out = r_reg.ovr;
endmodule : snfe_core
`default_nettype wire

//--- hw/snfe_fifo.sv
// small valid/ready fifo for program data heading to the array
`timescale 1ns/1ps
`default_nettype none
module snfe_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_sys_in, // system clock
  input wire logic rst_in, // async reset, active high
  input wire logic in_valid_in, // word offered
  output logic in_ready_out, // room for a word
  input wire logic [W-1:0] in_data_in, // word in
  output logic out_valid_out, // word available
  input wire logic out_ready_in, // drain side takes word
  output logic [W-1:0] out_data_out // oldest word
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } snfe_fifo_s;

  snfe_fifo_s r_reg;
  snfe_fifo_s r_next;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready_out = (r_reg.cnt != FULL);
  assign out_valid_out = (r_reg.cnt != '0);
  assign out_data_out = r_reg.mem[r_reg.rp];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // pointer and count update
  always_comb
  begin
    r_next = r_reg;
    if (push)
    begin
      r_next.mem[r_reg.wp] = in_data_in;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop)
      r_next.rp = r_reg.rp + 1'b1;
    if (push & ~pop)
      r_next.cnt = r_reg.cnt + 1'b1;
    else if (pop & ~push)
      r_next.cnt = r_reg.cnt - 1'b1;
  end

  // state register
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end
endmodule : snfe_fifo
`default_nettype wire

//--- hw/snfe_pkg.sv
// constants, commands and types of the serial nor flash front end
package snfe_pkg;

  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int ARRAY_BYTES = 262144;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_BYTES = 4096;
  localparam int BLOCK_BYTES = 65536;
  localparam logic [ADDR_W-1:0] PAGE_MASK = 18'h3_FF00;
  localparam logic [ADDR_W-1:0] SECTOR_MASK = 18'h3_F000;
  localparam logic [ADDR_W-1:0] HALF_MASK = 18'h3_8000;
  localparam logic [ADDR_W-1:0] BLOCK_MASK = 18'h3_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;

  // ---------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RD_STATUS = 8'h05;
  localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
  localparam logic [7:0] CMD_WR_STATUS = 8'h01;
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] CMD_FOUR_K_WIPE = 8'h20;
  localparam logic [7:0] CMD_BLOCK_WIPE = 8'hD8;
  localparam logic [7:0] CMD_HALF_WIPE = 8'h52;
  localparam logic [7:0] CMD_ARRAY_WIPE_A = 8'hC7;
  localparam logic [7:0] CMD_ARRAY_WIPE_B = 8'h60;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_DUAL_READ = 8'h3B;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] CMD_WAKE_ID = 8'hAB;
  localparam logic [7:0] CMD_MAKER_ID = 8'h90;
  localparam logic [7:0] CMD_JEDEC_IDENT = 8'h9F;
  localparam logic [7:0] CMD_UNIQUE_ID = 8'h4B;

  // ---------------------------------------------------------------
  // counts and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_BYTES = 3'd3;
  localparam logic [2:0] ADDR_DUMMY_BYTES = 3'd4;
  localparam logic [2:0] LAST_BIT = 3'd7;
  localparam logic [3:0] JEDEC_LAST = 4'd2;
  localparam logic [2:0] GUARD_RST = 3'b000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int FIFO_DEPTH = 4;
  localparam int PW_W = ADDR_W + 8;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_PROG, OP_SECTOR, OP_HALF, OP_BLOCK, OP_CHIP, OP_STATUS
  } snfe_op_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DIN, ST_DOUT, ST_HOLD, ST_SKIP
  } snfe_state_e;

endpackage : snfe_pkg

//--- hw/snfe_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module snfe_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_in, // system clock
  input wire logic rst_in, // async reset, active high
  input wire logic [W-1:0] async_in, // pin levels
  output logic [W-1:0] sync_out // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } snfe_sync_s;

  snfe_sync_s r_reg;
  snfe_sync_s r_next;

  // first stage feeds only the second
  always_comb
  begin
    r_next.meta = async_in;
    r_next.stable = r_reg.meta;
  end

  // state register
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign sync_out = r_reg.stable;
endmodule : snfe_sync
`default_nettype wire

//--- tb/snfe_array_model.sv
// array side model: read data, program drain, operation timing
`timescale 1ns/1ps
`default_nettype none
module snfe_array_model (
  input wire logic clk_sys_in, // system clock
  input wire logic rst_in, // async reset
  input wire logic [snfe_pkg::ADDR_W-1:0] rd_addr_in, // read address
  output logic [7:0] rd_data_out, // byte at address
  output logic prog_ready_out, // drain ready
  input wire logic op_start_in, // launch pulse
  output logic op_done_out // finished pulse
);
  import snfe_pkg::*;
  int cnt;
  // data a clk after address; drain stalls every other clk
  always_ff @(posedge clk_sys_in or posedge rst_in)
    if (rst_in)
    begin
      rd_data_out <= 8'h00;
      prog_ready_out <= 1'b0;
      op_done_out <= 1'b0;
      cnt <= 0;
    end
    else
    begin
      rd_data_out <= rd_addr_in[7:0] + rd_addr_in[15:8];
      prog_ready_out <= ~prog_ready_out;
      op_done_out <= (cnt == 1);
      if (op_start_in)
        cnt <= 600;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
endmodule : snfe_array_model
`default_nettype wire

//--- tb/snfe_assertions.sv
// port checker for the flash front end
`timescale 1ns/1ps
`default_nettype none
module snfe_assertions (
  input wire logic clk_sys_in, // system clock
  input wire logic rst_in, // async reset
  input wire logic sclk_in, // serial clock
  input wire logic select_n_in, // select pin
  input wire logic bidir_lane_zero_oe_out, // lane zero driven
  input wire logic out_lane_one_out, // serial out value
  input wire logic out_lane_one_oe_out, // serial out driven
  input wire logic op_start_out, // launch pulse
  input wire snfe_pkg::snfe_op_e op_kind_out, // launched kind
  input wire logic [snfe_pkg::ADDR_W-1:0] op_addr_out, // base
  input wire logic op_done_in, // finished pulse
  input wire logic [7:0] status_out, // status byte
  input wire logic prog_valid_out, // program word offered
  input wire logic prog_ready_in, // program word taken
  input wire logic [snfe_pkg::ADDR_W-1:0] prog_addr_out, // address
  input wire logic [7:0] prog_data_out // data
);
  import snfe_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence idle_s;
    select_n_in [*6];
  endsequence
  sequence launch_s;
    op_start_out;
  endsequence
  a_idle_released:
    assert property (idle_s |-> !out_lane_one_oe_out &&
      !bidir_lane_zero_oe_out) else $error("lane driven while idle");
  a_out_on_fall:
    assert property ($changed(out_lane_one_out) && out_lane_one_oe_out
      |-> !$past(sclk_in, 2)) else $error("output moved off fall");
  a_dual_paired:
    assert property (bidir_lane_zero_oe_out |-> out_lane_one_oe_out)
      else $error("lane zero driven alone");
  a_start_single:
    assert property (launch_s |=> !op_start_out)
      else $error("launch pulse too long");
  a_start_sets_busy:
    assert property (launch_s |-> status_out[0] && !status_out[1])
      else $error("launch without busy or with arm");
  a_busy_blocks_start:
    assert property (status_out[0] && !op_done_in |=> !op_start_out)
      else $error("launch while busy");
  a_sector_aligned:
    assert property (launch_s ##0 op_kind_out == OP_SECTOR |->
      (op_addr_out & ~SECTOR_MASK) == '0) else $error("sector base");
  a_block_aligned:
    assert property (launch_s ##0 op_kind_out == OP_BLOCK |->
      (op_addr_out & ~BLOCK_MASK) == '0) else $error("block base");
  a_prog_word_held:
    assert property (prog_valid_out && !prog_ready_in |=> prog_valid_out
      && $stable(prog_addr_out) && $stable(prog_data_out))
      else $error("program word dropped");
endmodule : snfe_assertions
bind snfe_core snfe_assertions chk_u (.clk_sys_in, .rst_in, .sclk_in,
  .select_n_in, .bidir_lane_zero_oe_out, .out_lane_one_out,
  .out_lane_one_oe_out, .op_start_out, .op_kind_out, .op_addr_out,
  .op_done_in, .status_out, .prog_valid_out, .prog_ready_in,
  .prog_addr_out, .prog_data_out);
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the flash front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import snfe_pkg::*;
  logic clk = 0, rst = 1, sclk = 0, sel_n = 0, mosi = 0, prot_n = 1;
  logic idle = 0, l0_o, l0_oe, l1_o, l1_oe, pv, pr, st, done, slp, ovr;
  logic [ADDR_W-1:0] ra, pa, oa;
  logic [7:0] rd, pd, sr, rx = 0;
  logic [7:0] rc[3] = '{CMD_READ, CMD_FAST_READ, CMD_DUAL_READ};
  logic [7:0] ec[5] = '{CMD_FOUR_K_WIPE, CMD_HALF_WIPE, CMD_BLOCK_WIPE,
    CMD_ARRAY_WIPE_A, CMD_ARRAY_WIPE_B};
  logic [ADDR_W-1:0] em[5] = '{SECTOR_MASK, HALF_MASK, BLOCK_MASK, 0, 0};
  snfe_op_e ek[5] = '{OP_SECTOR, OP_HALF, OP_BLOCK, OP_CHIP, OP_CHIP};
  snfe_op_e ok;
  logic [7:0] rq[$];
  logic [25:0] pq[$];
  int errors = 0, tests_run = 0, starts = 0, n;
  always #10 clk = ~clk;
  snfe_core dut_u (.clk_sys_in(clk), .rst_in(rst), .sclk_in(sclk),
    .select_n_in(sel_n), .bidir_lane_zero_in(l0_oe ? l0_o : mosi),
    .bidir_lane_zero_out(l0_o), .bidir_lane_zero_oe_out(l0_oe),
    .out_lane_one_out(l1_o), .out_lane_one_oe_out(l1_oe),
    .protect_n_in(prot_n), .rd_addr_out(ra), .rd_data_in(rd),
    .prog_valid_out(pv), .prog_ready_in(pr), .prog_addr_out(pa),
    .prog_data_out(pd), .op_start_out(st), .op_kind_out(ok),
    .op_addr_out(oa), .op_done_in(done), .status_out(sr),
    .sleep_out(slp), .overrun_out(ovr));
  snfe_array_model mdl_u (.clk_sys_in(clk), .rst_in(rst),
    .rd_addr_in(ra), .rd_data_out(rd), .prog_ready_out(pr),
    .op_start_in(st), .op_done_out(done));
  // ----
  // monitors and helpers
  // ----
  // log launches and drained program words, away from the launch edge
  always @(negedge clk)
  begin
    if (st)
      starts++;
    if (pv && pr)
      pq.push_back({pa, pd});
  end
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic chk(input logic [25:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one byte, or four bit pairs in dual mode; 160 ns serial clock
  task automatic xb(input logic [7:0] tx, input bit dual);
    for (int i = 0; i < (dual ? 4 : 8); i++)
    begin
      sclk = 0;
      mosi = tx[7-i];
      tick(4);
      sclk = 1;
      rx = dual ? {rx[5:0], l1_o, l0_o} : {rx[6:0], l1_o};
      tick(4);
    end
  endtask : xb
  // whole frame: code, address, extra bytes d+i, then nr reads
  task automatic fr(input logic [7:0] c, input logic [23:0] a,
      input int na, input logic [7:0] d, input int nd, nr,
      input bit dual, rise);
    sclk = idle;
    if (rise)
    begin
      sel_n = 1;
      tick(4);
    end
    sel_n = 0;
    tick(4);
    xb(c, 0);
    for (int i = na - 1; i >= 0; i--)
      xb(a[8*i+:8], 0);
    for (int i = 0; i < nd; i++)
      xb(8'(d + i), 0);
    for (int i = 0; i < nr; i++)
    begin
      xb(8'h00, dual);
      rq.push_back(rx);
    end
    sclk = idle;
    tick(4);
    sel_n = 1;
    tick(6);
  endtask : fr
  task automatic cmd(input logic [7:0] c);
    fr(c, 0, 0, 0, 0, 0, 0, 1);
  endtask : cmd
  task automatic rs;
    fr(CMD_RD_STATUS, 0, 0, 0, 0, 1, 0, 1);
  endtask : rs
  task automatic wait_idle;
    for (int t = 0; t < 2000 && sr[0] !== 1'b0; t++)
      tick(1);
    chk(sr[0], 1'b0);
  endtask : wait_idle
  task automatic test_done;
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // ----
  // tests
  // ----
  // hang guard
  initial
  begin
    tick(60000);
    errors++;
    test_done;
  end
  // main sequence
  initial
  begin
    tick(5);
    rst = 0;
    tick(2);
    fr(CMD_WR_ENABLE, 0, 0, 0, 0, 0, 0, 0);
    rs;
    chk(rq.pop_front(), 8'h00);
    cmd(CMD_WR_ENABLE);
    rs;
    chk(rq.pop_front(), 8'h02);
    cmd(CMD_WR_DISABLE);
    rs;
    chk(rq.pop_front(), 8'h00);
    idle = 1;
    fr(CMD_JEDEC_IDENT, 0, 0, 0, 0, 3, 0, 1);
    idle = 0;
    chk(rq.pop_front(), 8'h5A);
    chk(rq.pop_front(), 8'h40);
    chk(rq.pop_front(), 8'h12);
    foreach (rc[i])
    begin
      fr(rc[i], 24'h00_FFFE, 3, 0, i > 0, 3, i == 2, 1);
      for (int k = 0; k < 3; k++)
        chk(rq.pop_front(), 8'(k - 3 + (k > 1)));
    end
    foreach (ec[i])
    begin
      n = starts;
      cmd(CMD_WR_ENABLE);
      fr(ec[i], 24'h02_BCDE, i < 3 ? 3 : 0, 0, 0, 0, 0, 1);
      chk(26'(starts - n), 1);
      chk({oa, 5'(ok)}, {18'h2_BCDE & em[i], 5'(ek[i])});
      cmd(CMD_WR_ENABLE);
      rs;
      chk(rq.pop_front(), 8'h01);
      wait_idle;
    end
    cmd(CMD_WR_ENABLE);
    fr(CMD_PAGE_WRITE, 24'h00_01FE, 3, 8'hA0, 3, 0, 0, 1);
    chk(ovr, 1'b0);
    wait_idle;
    chk({oa, 5'(ok)}, {18'h0_0100, 5'(OP_PROG)});
    chk(pq.pop_front(), {18'h0_01FE, 8'hA0});
    chk(pq.pop_front(), {18'h0_01FF, 8'hA1});
    chk(pq.pop_front(), {18'h0_0100, 8'hA2});
    cmd(CMD_WR_ENABLE);
    fr(CMD_WR_STATUS, 0, 0, 8'h9C, 1, 0, 0, 1);
    wait_idle;
    rs;
    chk(rq.pop_front(), 8'h9C);
    prot_n = 0;
    n = starts;
    cmd(CMD_WR_ENABLE);
    fr(CMD_WR_STATUS, 0, 0, 8'h00, 1, 0, 0, 1);
    rs;
    chk({rq.pop_front() & 8'hFC, 8'(starts - n)}, 16'h9C00);
    cmd(CMD_DEEP_SLEEP);
    chk(slp, 1'b1);
    fr(CMD_WAKE_ID, 0, 0, 0, 3, 1, 0, 1);
    chk({slp, rq.pop_front()}, 9'h011);
    fr(CMD_MAKER_ID, 0, 3, 0, 0, 2, 0, 1);
    chk(rq.pop_front(), 8'h5A);
    chk(rq.pop_front(), 8'h11);
    fr(CMD_UNIQUE_ID, 0, 0, 0, 4, 2, 0, 1);
    chk(rq.pop_front(), 8'h01);
    chk(rq.pop_front(), 8'h23);
    test_done;
  end
endmodule : testbench
`default_nettype wire
